// >>> pkg/csbs_pkg.sv
// constants and types for the core status and bank select block
package csbs_pkg;

  // ==========================================================================
  // special register addresses, decoded alike in every bank
  localparam logic [7:0] SFR_TOP = 8'h40;
  localparam logic [7:0] ADDR_IPORT1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_PCL = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE_LATCH = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
  localparam logic [7:0] ADDR_STATUS = 8'h0A;

  // ==========================================================================
  // nv memory control register location
  localparam logic [7:0] NV_CTRL_ADDR = 8'h40;
  localparam logic [2:0] NV_CTRL_BANK = 3'h1;

  // ==========================================================================
  // bank select layout
  localparam logic [7:0] BP_RESET = 8'h00;
  localparam logic [7:0] BP_MASK_1 = 8'h01;
  localparam logic [7:0] BP_MASK_2 = 8'h03;
  localparam logic [7:0] BP_MASK_3 = 8'h27;
  localparam int unsigned BP_PROG_BIT = 5;
  localparam logic [1:0] BANK2_UNDEF = 2'h3;
  localparam logic [2:0] BANK3_LAST = 3'h4;

  // ==========================================================================
  // status layout
  localparam int unsigned ST_TO = 5;
  localparam int unsigned ST_PDF = 4;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_AC = 1;
  localparam int unsigned ST_C = 0;
  localparam logic [3:0] ARITH_RESET = 4'h0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    CSBS_OP_NONE,
    CSBS_OP_ADD,
    CSBS_OP_ADC,
    CSBS_OP_SUB,
    CSBS_OP_SBC,
    CSBS_OP_LOGIC,
    CSBS_OP_RLC,
    CSBS_OP_RRC
  } csbs_op_e;

  typedef enum logic [1:0] {
    CSBS_SRC_ZERO,
    CSBS_SRC_MEM,
    CSBS_SRC_SFR
  } csbs_src_e;

endpackage : csbs_pkg

// >>> core/csbs_bank_decode.sv
// data bank decode for the configured bank select width
module csbs_bank_decode #(
  parameter int unsigned BANK_BITS = 3
) (
  // bank select value
  input wire logic [7:0] bank_select_i,
  // decoded bank
  output logic [2:0] bank_o,
  output logic valid_o
);

  // ==========================================================================
  // decode
  always_comb begin
    case (BANK_BITS)
      1: begin
        bank_o = {2'h0, bank_select_i[0]};
        valid_o = 1'b1;
      end
      2: begin
        bank_o = {1'b0, bank_select_i[1:0]};
        valid_o = bank_select_i[1:0] != csbs_pkg::BANK2_UNDEF;
      end
      default: begin
        bank_o = bank_select_i[2:0];
        valid_o = bank_select_i[2:0] <= csbs_pkg::BANK3_LAST;
      end
    endcase
  end

endmodule : csbs_bank_decode

// >>> core/csbs_alu_flags.sv
// arithmetic flag computation for one alu operation
module csbs_alu_flags (
  // operation
  input wire csbs_pkg::csbs_op_e op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic c_i,
  // flags and which of them the operation touches
  output logic c_o,
  output logic ac_o,
  output logic z_o,
  output logic ov_o,
  output logic wr_c_o,
  output logic wr_ac_o,
  output logic wr_z_o,
  output logic wr_ov_o
);

  logic [7:0] b_eff;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] lo8;
  logic arith;

  // ==========================================================================
  // add and subtract share one adder, subtract adds the inverse
  always_comb begin
    arith = op_i inside {csbs_pkg::CSBS_OP_ADD, csbs_pkg::CSBS_OP_ADC,
                         csbs_pkg::CSBS_OP_SUB, csbs_pkg::CSBS_OP_SBC};
    b_eff = b_i;
    cin = 1'b0;
    case (op_i)
      csbs_pkg::CSBS_OP_ADC: cin = c_i;
      csbs_pkg::CSBS_OP_SUB: begin
        b_eff = ~b_i;
        cin = 1'b1;
      end
      csbs_pkg::CSBS_OP_SBC: begin
        b_eff = ~b_i;
        cin = c_i;
      end
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin};
    lo5 = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    lo8 = {1'b0, a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
    c_o = sum9[8];
    ac_o = lo5[4];
    ov_o = lo8[7] ^ sum9[8];
    z_o = sum9[7:0] == 8'h00;
    case (op_i)
      csbs_pkg::CSBS_OP_LOGIC: z_o = b_i == 8'h00;
      csbs_pkg::CSBS_OP_RLC: c_o = a_i[7];
      csbs_pkg::CSBS_OP_RRC: c_o = a_i[0];
      default: z_o = sum9[7:0] == 8'h00;
    endcase
    wr_c_o = arith || op_i inside {csbs_pkg::CSBS_OP_RLC,
                                   csbs_pkg::CSBS_OP_RRC};
    wr_ac_o = arith;
    wr_ov_o = arith;
    wr_z_o = arith || op_i == csbs_pkg::CSBS_OP_LOGIC;
  end

endmodule : csbs_alu_flags

// >>> core/csbs_core_regs.sv
// core special registers: bank select, status flags, pcl, table read
// Operation
// - one-bit variant: bit 0 picks bank 0/1
// - two-bit variant: codes 00..10 banks, 11 undefined
// - three-bit variant: 000..100 banks, others undefined
// - largest variant: bit 5 selects program bank
// - unimplemented bank bits read zero, reset zero
// - pcl write jumps within current page
// - pcl jump inserts one dummy cycle
// - table read: high byte latched, low returned
// - status writes never touch expiry or halt flags
// - expiry flag cleared by clear/sleep, set by timeout
// - halt flag cleared by clear, set by sleep
// - carry from add, no-borrow, rotate through carry
// - half carry from low nibble carry/no-borrow
// - zero flag follows result equal zero
// - overflow is carry-in xor carry-out of msb
// - status is never pushed on call/interrupt
// - status layout: bits 5,4 read-only, 7,6 zero
// - no direct register to register move
// - direct addressing always reaches bank 0
// - resets clear bank except watchdog in halt
module csbs_core_regs #(
  parameter int unsigned BANK_BITS = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // other reset sources
  input wire logic sys_reset_i,
  input wire logic keep_bank_i,
  // data access from datapath
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // data memory side
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [2:0] mem_bank_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic nv_ctrl_sel_o,
  input wire logic [7:0] mem_rdata_i,
  // program counter
  input wire logic [7:0] pc_low_i,
  output logic pc_jump_o,
  output logic [7:0] pc_target_o,
  output logic dummy_cycle_o,
  // table read
  input wire logic tbl_req_i,
  output logic prog_rd_o,
  output logic [15:0] prog_addr_o,
  input wire logic prog_valid_i,
  input wire logic [15:0] prog_data_i,
  output logic [7:0] tbl_low_o,
  output logic tbl_low_valid_o,
  // alu flag update and system events
  input wire csbs_pkg::csbs_op_e alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  input wire logic wdt_timeout_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic halt_i,
  // register views
  output logic [7:0] status_o,
  output logic [7:0] bank_select_o,
  output logic prog_bank_o
);

  localparam logic [7:0] BP_MASK = (BANK_BITS == 1) ? csbs_pkg::BP_MASK_1 :
    (BANK_BITS == 2) ? csbs_pkg::BP_MASK_2 : csbs_pkg::BP_MASK_3;

  logic [7:0] bp_reg, bp_next, ptr1_reg, ptr1_next;
  logic [7:0] table_pointer_low_reg, table_pointer_low_next, table_pointer_high_reg, table_pointer_high_next;
  logic [7:0] table_high_byte_latch_reg, table_high_byte_latch_next;
  logic to_reg, to_next, pdf_reg, pdf_next;
  logic [3:0] ar_reg, ar_next;
  logic mem_req_reg, mem_req_next, mem_we_reg, mem_we_next;
  logic [2:0] mem_bank_reg, mem_bank_next;
  logic [7:0] mem_addr_reg, mem_addr_next, mem_wdata_reg, mem_wdata_next;
  logic nv_reg, nv_next, rd_pend_reg, rd_pend_next;
  csbs_pkg::csbs_src_e src_reg, src_next;
  logic [7:0] sfr_q_reg, sfr_q_next, rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic pc_jump_reg, pc_jump_next, dummy_reg, dummy_next;
  logic [7:0] pc_target_reg, pc_target_next;
  logic prog_rd_reg, prog_rd_next;
  logic [15:0] prog_addr_reg, prog_addr_next;
  logic [7:0] tbl_low_reg, tbl_low_next;
  logic tbl_lv_reg, tbl_lv_next;

  logic [2:0] dec_bank;
  logic dec_valid;
  logic f_c, f_ac, f_z, f_ov, w_c, w_ac, w_z, w_ov;
  logic indirect, is_sfr, own, zero_acc, fwd, wr_own;
  logic [7:0] eff_addr, sfr_rd;
  logic [2:0] bank_use;

  // ==========================================================================
  // sub blocks
  csbs_bank_decode #(
    .BANK_BITS(BANK_BITS)
  ) u_dec (
    .bank_select_i(bp_reg),
    .bank_o(dec_bank),
    .valid_o(dec_valid)
  );

  csbs_alu_flags u_alu (
    .op_i(alu_op_i),
    .a_i(alu_a_i),
    .b_i(alu_b_i),
    .c_i(ar_reg[csbs_pkg::ST_C]),
    .c_o(f_c),
    .ac_o(f_ac),
    .z_o(f_z),
    .ov_o(f_ov),
    .wr_c_o(w_c),
    .wr_ac_o(w_ac),
    .wr_z_o(w_z),
    .wr_ov_o(w_ov)
  );

  // ==========================================================================
  // access decode
  always_comb begin
    indirect = acc_addr_i == csbs_pkg::ADDR_IPORT1;
    eff_addr = indirect ? ptr1_reg : acc_addr_i;
    is_sfr = eff_addr < csbs_pkg::SFR_TOP;
    own = is_sfr && eff_addr inside {csbs_pkg::ADDR_PTR1,
      csbs_pkg::ADDR_BANK, csbs_pkg::ADDR_PCL, csbs_pkg::ADDR_TABLE_POINTER_LOW,
      csbs_pkg::ADDR_TABLE_HIGH_BYTE_LATCH, csbs_pkg::ADDR_TABLE_POINTER_HIGH, csbs_pkg::ADDR_STATUS};
    bank_use = (indirect && !is_sfr) ? dec_bank : 3'h0;
    zero_acc = (indirect && eff_addr == csbs_pkg::ADDR_IPORT1) ||
               (indirect && !is_sfr && !dec_valid);
    fwd = !own && !zero_acc;
    wr_own = acc_valid_i && acc_write_i && own;
    case (eff_addr)
      csbs_pkg::ADDR_PTR1: sfr_rd = ptr1_reg;
      csbs_pkg::ADDR_BANK: sfr_rd = bp_reg;
      csbs_pkg::ADDR_PCL: sfr_rd = pc_low_i;
      csbs_pkg::ADDR_TABLE_POINTER_LOW: sfr_rd = table_pointer_low_reg;
      csbs_pkg::ADDR_TABLE_HIGH_BYTE_LATCH: sfr_rd = table_high_byte_latch_reg;
      csbs_pkg::ADDR_TABLE_POINTER_HIGH: sfr_rd = table_pointer_high_reg;
      csbs_pkg::ADDR_STATUS: sfr_rd = status_o;
      default: sfr_rd = 8'h00;
    endcase
  end

  // ==========================================================================
  // register state next values
  always_comb begin
    bp_next = bp_reg;
    ptr1_next = ptr1_reg;
    table_pointer_low_next = table_pointer_low_reg;
    table_pointer_high_next = table_pointer_high_reg;
    table_high_byte_latch_next = table_high_byte_latch_reg;
    ar_next = ar_reg;
    to_next = to_reg;
    pdf_next = pdf_reg;
    if (sys_reset_i && !keep_bank_i) begin
      bp_next = csbs_pkg::BP_RESET;
    end else if (wr_own && eff_addr == csbs_pkg::ADDR_BANK) begin
      bp_next = acc_wdata_i & BP_MASK;
    end
    // writes carry only the working register value
    if (wr_own && eff_addr == csbs_pkg::ADDR_PTR1) begin
      ptr1_next = acc_wdata_i;
    end
    if (wr_own && eff_addr == csbs_pkg::ADDR_TABLE_POINTER_LOW) begin
      table_pointer_low_next = acc_wdata_i;
    end
    if (wr_own && eff_addr == csbs_pkg::ADDR_TABLE_POINTER_HIGH) begin
      table_pointer_high_next = acc_wdata_i;
    end
    if (prog_valid_i) begin
      table_high_byte_latch_next = prog_data_i[15:8];
    end
    if (w_c) begin
      ar_next[csbs_pkg::ST_C] = f_c;
    end
    if (w_ac) begin
      ar_next[csbs_pkg::ST_AC] = f_ac;
    end
    if (w_z) begin
      ar_next[csbs_pkg::ST_Z] = f_z;
    end
    if (w_ov) begin
      ar_next[csbs_pkg::ST_OV] = f_ov;
    end
    // a status write lands in the arithmetic flags only
    if (wr_own && eff_addr == csbs_pkg::ADDR_STATUS) begin
      ar_next = acc_wdata_i[3:0];
    end
    if (watchdog_clear_instruction_i || halt_i) begin
      to_next = 1'b0;
    end
    if (wdt_timeout_i) begin
      to_next = 1'b1;
    end
    if (watchdog_clear_instruction_i) begin
      pdf_next = 1'b0;
    end
    if (halt_i) begin
      pdf_next = 1'b1;
    end
  end

  // ==========================================================================
  // access, jump and table pipeline next values
  always_comb begin
    mem_req_next = acc_valid_i && fwd;
    mem_we_next = acc_valid_i && acc_write_i && fwd;
    mem_bank_next = bank_use;
    mem_addr_next = eff_addr;
    mem_wdata_next = acc_wdata_i;
    nv_next = acc_valid_i && fwd && indirect &&
              bank_use == csbs_pkg::NV_CTRL_BANK &&
              eff_addr == csbs_pkg::NV_CTRL_ADDR;
    rd_pend_next = acc_valid_i && !acc_write_i;
    src_next = own ? csbs_pkg::CSBS_SRC_SFR :
               fwd ? csbs_pkg::CSBS_SRC_MEM : csbs_pkg::CSBS_SRC_ZERO;
    sfr_q_next = sfr_rd;
    rvalid_next = rd_pend_reg;
    case (src_reg)
      csbs_pkg::CSBS_SRC_MEM: rdata_next = mem_rdata_i;
      csbs_pkg::CSBS_SRC_SFR: rdata_next = sfr_q_reg;
      default: rdata_next = 8'h00;
    endcase
    pc_jump_next = wr_own && eff_addr == csbs_pkg::ADDR_PCL;
    pc_target_next = pc_jump_next ? acc_wdata_i : pc_target_reg;
    dummy_next = pc_jump_reg;
    prog_rd_next = tbl_req_i;
    prog_addr_next = tbl_req_i ? {table_pointer_high_reg, table_pointer_low_reg} : prog_addr_reg;
    tbl_lv_next = prog_valid_i;
    tbl_low_next = prog_valid_i ? prog_data_i[7:0] : tbl_low_reg;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bp_reg <= csbs_pkg::BP_RESET;
      ptr1_reg <= 8'h00;
      table_pointer_low_reg <= 8'h00;
      table_pointer_high_reg <= 8'h00;
      table_high_byte_latch_reg <= 8'h00;
      ar_reg <= csbs_pkg::ARITH_RESET;
      to_reg <= 1'b0;
      pdf_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_bank_reg <= 3'h0;
      mem_addr_reg <= 8'h00;
      mem_wdata_reg <= 8'h00;
      nv_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      src_reg <= csbs_pkg::CSBS_SRC_ZERO;
      sfr_q_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      pc_jump_reg <= 1'b0;
      pc_target_reg <= 8'h00;
      dummy_reg <= 1'b0;
      prog_rd_reg <= 1'b0;
      prog_addr_reg <= 16'h0000;
      tbl_low_reg <= 8'h00;
      tbl_lv_reg <= 1'b0;
    end else begin
      bp_reg <= bp_next;
      ptr1_reg <= ptr1_next;
      table_pointer_low_reg <= table_pointer_low_next;
      table_pointer_high_reg <= table_pointer_high_next;
      table_high_byte_latch_reg <= table_high_byte_latch_next;
      ar_reg <= ar_next;
      to_reg <= to_next;
      pdf_reg <= pdf_next;
      mem_req_reg <= mem_req_next;
      mem_we_reg <= mem_we_next;
      mem_bank_reg <= mem_bank_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      nv_reg <= nv_next;
      rd_pend_reg <= rd_pend_next;
      src_reg <= src_next;
      sfr_q_reg <= sfr_q_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      pc_jump_reg <= pc_jump_next;
      pc_target_reg <= pc_target_next;
      dummy_reg <= dummy_next;
      prog_rd_reg <= prog_rd_next;
      prog_addr_reg <= prog_addr_next;
      tbl_low_reg <= tbl_low_next;
      tbl_lv_reg <= tbl_lv_next;
    end
  end

  // ==========================================================================
  // outputs, status is a plain view with no stack path
  assign status_o = {2'b00, to_reg, pdf_reg, ar_reg};
  assign bank_select_o = bp_reg;
  assign prog_bank_o = bp_reg[csbs_pkg::BP_PROG_BIT];
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign mem_req_o = mem_req_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_bank_o = mem_bank_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign nv_ctrl_sel_o = nv_reg;
  assign pc_jump_o = pc_jump_reg;
  assign pc_target_o = pc_target_reg;
  assign dummy_cycle_o = dummy_reg;
  assign prog_rd_o = prog_rd_reg;
  assign prog_addr_o = prog_addr_reg;
  assign tbl_low_o = tbl_low_reg;
  assign tbl_low_valid_o = tbl_lv_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_bank_unimpl: assert property (
    (bank_select_o & ~BP_MASK) == 8'h00)
    else $error("unimplemented bank bit set");
  a_bank_reset: assert property (
    sys_reset_i && !keep_bank_i |=> bank_select_o == 8'h00)
    else $error("bank not cleared by reset");
  a_bank_kept: assert property (
    sys_reset_i && keep_bank_i && !wr_own |=> $stable(bank_select_o))
    else $error("bank lost on watchdog halt reset");
  a_direct_bank0: assert property (
    acc_valid_i && !indirect |=> mem_bank_o == 3'h0)
    else $error("direct access left bank 0");
  a_undef_zero: assert property (
    acc_valid_i && zero_acc && !acc_write_i |=> !mem_req_o ##1
    rvalid_o && rdata_o == 8'h00)
    else $error("undefined bank read not zero");
  a_pcl_jump: assert property (
    wr_own && eff_addr == csbs_pkg::ADDR_PCL |=>
    pc_jump_o && pc_target_o == $past(acc_wdata_i))
    else $error("pcl write did not jump");
  a_dummy_one: assert property (
    $rose(pc_jump_o) && !pc_jump_next |=> dummy_cycle_o ##1 !dummy_cycle_o)
    else $error("dummy cycle not single");
  a_tbl_addr: assert property (
    tbl_req_i |=> prog_rd_o && prog_addr_o == $past({table_pointer_high_reg, table_pointer_low_reg}))
    else $error("table address wrong");
  a_tbl_latch: assert property (
    prog_valid_i |=> tbl_low_valid_o && tbl_low_o == $past(prog_data_i[7:0])
    && table_high_byte_latch_reg == $past(prog_data_i[15:8]))
    else $error("table data not latched");
  a_status_keep: assert property (
    wr_own && eff_addr == csbs_pkg::ADDR_STATUS && !wdt_timeout_i &&
    !watchdog_clear_instruction_i && !halt_i |=> $stable(status_o[5:4]))
    else $error("status write moved system flags");
  a_to_set: assert property (
    wdt_timeout_i |=> status_o[csbs_pkg::ST_TO])
    else $error("timeout flag not set");
  a_pdf_track: assert property (
    halt_i && !wdt_timeout_i |=>
    status_o[csbs_pkg::ST_PDF] && !status_o[csbs_pkg::ST_TO])
    else $error("halt flags wrong");
  a_high_zero: assert property (
    status_o[7:6] == 2'b00)
    else $error("status high bits not zero");

  c_pcl_jump: cover property (pc_jump_o ##1 dummy_cycle_o);
  c_nv_ctrl: cover property (nv_ctrl_sel_o && mem_we_o);
  c_tbl_read: cover property (prog_rd_o ##[1:4] tbl_low_valid_o);
  c_undef_bank: cover property (acc_valid_i && zero_acc);

endmodule : csbs_core_regs

// >>> testbench/tb.sv
// self-checking testbench for the core status and bank select registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_n_i, sys_reset_i, keep_bank_i, acc_valid_i, acc_write_i;
  logic rvalid_o, mem_req_o, mem_we_o, nv_ctrl_sel_o, pc_jump_o;
  logic dummy_cycle_o, tbl_req_i, prog_rd_o, prog_valid_i;
  logic tbl_low_valid_o, wdt_timeout_i, watchdog_clear_instruction_i, halt_i, prog_bank_o;
  logic [7:0] acc_addr_i, acc_wdata_i, rdata_o, mem_addr_o, mem_wdata_o;
  logic [7:0] mem_rdata_i, pc_low_i, pc_target_o, tbl_low_o, alu_a_i;
  logic [7:0] alu_b_i, status_o, bank_select_o, got;
  logic [2:0] mem_bank_o, seen_bank;
  logic [15:0] prog_addr_o, prog_data_i;
  csbs_pkg::csbs_op_e alu_op_i;
  logic seen_req, seen_nv;
  int bad_count = 0;
  int comparisons = 0;

  always #4 clk_i = ~clk_i;

  // data memory answers during the request cycle, a moving pattern otherwise
  always_comb begin
    if (mem_req_o === 1'b1) begin
      mem_rdata_i = mem_addr_o ^ {5'h00, mem_bank_o};
    end else begin
      mem_rdata_i = {clk_i, 7'h35};
    end
  end

  csbs_core_regs #(.BANK_BITS(3)) dut (
    .clk_i, .rst_n_i, .sys_reset_i, .keep_bank_i, .acc_valid_i,
    .acc_write_i, .acc_addr_i, .acc_wdata_i, .rdata_o, .rvalid_o,
    .mem_req_o, .mem_we_o, .mem_bank_o, .mem_addr_o, .mem_wdata_o,
    .nv_ctrl_sel_o, .mem_rdata_i, .pc_low_i, .pc_jump_o, .pc_target_o,
    .dummy_cycle_o, .tbl_req_i, .prog_rd_o, .prog_addr_o, .prog_valid_i,
    .prog_data_i, .tbl_low_o, .tbl_low_valid_o, .alu_op_i, .alu_a_i,
    .alu_b_i, .wdt_timeout_i, .watchdog_clear_instruction_i, .halt_i, .status_o,
    .bank_select_o, .prog_bank_o
  );

  // ==========================================================================
  // compare and verdict
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    acc_valid_i = 1'b1;
    acc_write_i = 1'b1;
    acc_addr_i = a;
    acc_wdata_i = d;
    @(negedge clk_i);
    acc_valid_i = 1'b0;
    acc_write_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    acc_valid_i = 1'b1;
    acc_addr_i = a;
    seen_req = 1'b0;
    seen_nv = 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_i);
      acc_valid_i = 1'b0;
      if (mem_req_o === 1'b1) begin
        seen_req = 1'b1;
        seen_bank = mem_bank_o;
      end
      if (nv_ctrl_sel_o === 1'b1) seen_nv = 1'b1;
      if (rvalid_o === 1'b1) break;
    end
    chk1(rvalid_o, 1'b1);
    d = rdata_o;
  endtask : rd

  task automatic ev(input logic t, input logic c, input logic h);
    @(negedge clk_i);
    wdt_timeout_i = t;
    watchdog_clear_instruction_i = c;
    halt_i = h;
    @(negedge clk_i);
    {wdt_timeout_i, watchdog_clear_instruction_i, halt_i} = 3'h0;
  endtask : ev

  task automatic alu1(input csbs_pkg::csbs_op_e op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] pre, input logic [7:0] m,
      input logic [7:0] e);
    wr(csbs_pkg::ADDR_STATUS, pre);
    @(negedge clk_i);
    alu_op_i = op;
    alu_a_i = a;
    alu_b_i = b;
    @(negedge clk_i);
    alu_op_i = csbs_pkg::CSBS_OP_NONE;
    chk8(status_o & m, e);
  endtask : alu1

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk8(bank_select_o, 8'h00);
    chk8(status_o, 8'h00);
    wr(csbs_pkg::ADDR_BANK, 8'hFF);
    chk8(bank_select_o, 8'h27);
    chk1(prog_bank_o, 1'b1);
    rd(csbs_pkg::ADDR_BANK, got);
    chk8(got, 8'h27);
    wr(csbs_pkg::ADDR_BANK, 8'h00);
    chk1(prog_bank_o, 1'b0);
  endtask : t_reset

  task automatic t_indirect();
    wr(csbs_pkg::ADDR_PTR1, 8'h50);
    for (int b = 0; b < 8; b++) begin
      wr(csbs_pkg::ADDR_BANK, 8'(b));
      wr(csbs_pkg::ADDR_IPORT1, 8'hA5);
      chk1(mem_we_o, (b <= 4) ? 1'b1 : 1'b0);
      if (b <= 4) begin
        chk8(mem_addr_o, 8'h50);
        chk8(mem_wdata_o, 8'hA5);
      end
      rd(csbs_pkg::ADDR_IPORT1, got);
      if (b <= 4) begin
        chk1(seen_req, 1'b1);
        chk8({5'h00, seen_bank}, 8'(b));
        chk8(got, 8'h50 ^ 8'(b));
      end else begin
        chk1(seen_req, 1'b0);
        chk8(got, 8'h00);
      end
    end
    wr(csbs_pkg::ADDR_BANK, 8'h03);
    rd(8'h50, got);
    chk8({5'h00, seen_bank}, 8'h00);
    rd(csbs_pkg::ADDR_PTR1, got);
    chk8(got, 8'h50);
    wr(csbs_pkg::ADDR_PTR1, 8'h40);
    wr(csbs_pkg::ADDR_BANK, 8'h01);
    rd(csbs_pkg::ADDR_IPORT1, got);
    chk1(seen_nv, 1'b1);
  endtask : t_indirect

  task automatic t_pcl();
    @(negedge clk_i);
    {acc_valid_i, acc_write_i} = 2'h3;
    acc_addr_i = csbs_pkg::ADDR_PCL;
    acc_wdata_i = 8'h3C;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      {acc_valid_i, acc_write_i} = 2'h0;
      if (pc_jump_o === 1'b1) break;
    end
    chk1(pc_jump_o, 1'b1);
    chk8(pc_target_o, 8'h3C);
    @(negedge clk_i);
    chk1(dummy_cycle_o, 1'b1);
    chk1(pc_jump_o, 1'b0);
  endtask : t_pcl

  task automatic t_table();
    wr(csbs_pkg::ADDR_TABLE_POINTER_LOW, 8'h34);
    wr(csbs_pkg::ADDR_TABLE_POINTER_HIGH, 8'h12);
    @(negedge clk_i);
    tbl_req_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      tbl_req_i = 1'b0;
      if (prog_rd_o === 1'b1) break;
    end
    chk1(prog_rd_o, 1'b1);
    chk8(prog_addr_o[15:8], 8'h12);
    chk8(prog_addr_o[7:0], 8'h34);
    prog_valid_i = 1'b1;
    prog_data_i = 16'hBEEF;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      prog_valid_i = 1'b0;
      prog_data_i = 16'h4110;
      if (tbl_low_valid_o === 1'b1) break;
    end
    chk1(tbl_low_valid_o, 1'b1);
    chk8(tbl_low_o, 8'hEF);
    wr(csbs_pkg::ADDR_TABLE_HIGH_BYTE_LATCH, 8'h00);
    rd(csbs_pkg::ADDR_TABLE_HIGH_BYTE_LATCH, got);
    chk8(got, 8'hBE);
  endtask : t_table

  task automatic t_status();
    wr(csbs_pkg::ADDR_STATUS, 8'hFF);
    chk8(status_o, 8'h0F);
    ev(1'b1, 1'b0, 1'b0);
    chk8(status_o, 8'h2F);
    ev(1'b0, 1'b0, 1'b1);
    chk8(status_o, 8'h1F);
    ev(1'b1, 1'b0, 1'b0);
    wr(csbs_pkg::ADDR_STATUS, 8'h00);
    chk8(status_o, 8'h30);
    ev(1'b0, 1'b1, 1'b0);
    chk8(status_o, 8'h00);
  endtask : t_status

  task automatic t_alu();
    alu1(csbs_pkg::CSBS_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h0F, 8'h0A);
    alu1(csbs_pkg::CSBS_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h0F, 8'h07);
    alu1(csbs_pkg::CSBS_OP_ADC, 8'h00, 8'h00, 8'h01, 8'h0F, 8'h00);
    alu1(csbs_pkg::CSBS_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h0F, 8'h07);
    alu1(csbs_pkg::CSBS_OP_SUB, 8'h00, 8'h01, 8'h0F, 8'h0F, 8'h00);
    alu1(csbs_pkg::CSBS_OP_SUB, 8'h80, 8'h01, 8'h00, 8'h0F, 8'h09);
    alu1(csbs_pkg::CSBS_OP_SBC, 8'h05, 8'h05, 8'h00, 8'h0F, 8'h00);
    alu1(csbs_pkg::CSBS_OP_LOGIC, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04);
    alu1(csbs_pkg::CSBS_OP_LOGIC, 8'h00, 8'h01, 8'h0F, 8'h04, 8'h00);
    alu1(csbs_pkg::CSBS_OP_RLC, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01);
    alu1(csbs_pkg::CSBS_OP_RRC, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01);
    alu1(csbs_pkg::CSBS_OP_NONE, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h0F);
  endtask : t_alu

  task automatic t_sysrst();
    wr(csbs_pkg::ADDR_STATUS, 8'h05);
    wr(csbs_pkg::ADDR_BANK, 8'h03);
    @(negedge clk_i);
    {sys_reset_i, keep_bank_i} = 2'h3;
    @(negedge clk_i);
    {sys_reset_i, keep_bank_i} = 2'h0;
    chk8(bank_select_o, 8'h03);
    @(negedge clk_i);
    sys_reset_i = 1'b1;
    @(negedge clk_i);
    sys_reset_i = 1'b0;
    chk8(bank_select_o, 8'h00);
    chk8(status_o, 8'h05);
  endtask : t_sysrst

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {rst_n_i, sys_reset_i, keep_bank_i, acc_valid_i, acc_write_i} = 5'h00;
    {tbl_req_i, prog_valid_i, wdt_timeout_i, watchdog_clear_instruction_i, halt_i} = 5'h00;
    {acc_addr_i, acc_wdata_i, alu_a_i, alu_b_i} = 32'h00000000;
    alu_op_i = csbs_pkg::CSBS_OP_NONE;
    pc_low_i = 8'h5D;
    prog_data_i = 16'hA55A;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_indirect();
    t_pcl();
    t_table();
    t_status();
    t_alu();
    t_sysrst();
    close_out();
  end

  initial begin
    #200000;
    bad_count++;
    close_out();
  end

endmodule : tb
